// ===== verilog/sem_monitor_fifo_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "monitor_port_map.svh"

module sem_monitor_fifo_port
    import monitor_port_pkg::*;
(
    // Clock and reset
    input  wire logic                    clock_in,
    input  wire logic                    rst_b_in,
    // AXI4-Lite write address and data
    input  wire logic [3:0]              s_axi_awaddr_in,
    input  wire logic                    s_axi_awvalid_in,
    output logic                         s_axi_awready_out,
    input  wire logic [31:0]             s_axi_wdata_in,
    input  wire logic [3:0]              s_axi_wstrb_in,
    input  wire logic                    s_axi_wvalid_in,
    output logic                         s_axi_wready_out,
    // AXI4-Lite write response
    output monitor_port_pkg::resp_t      s_axi_bresp_out,
    output logic                         s_axi_bvalid_out,
    input  wire logic                    s_axi_bready_in,
    // AXI4-Lite read
    input  wire logic [3:0]              s_axi_araddr_in,
    input  wire logic                    s_axi_arvalid_in,
    output logic                         s_axi_arready_out,
    output logic [31:0]                  s_axi_rdata_out,
    output monitor_port_pkg::resp_t      s_axi_rresp_out,
    output logic                         s_axi_rvalid_out,
    input  wire logic                    s_axi_rready_in,
    // Monitor side, incoming bytes
    input  wire logic                    received_byte_valid_in,
    input  wire monitor_port_pkg::byte_t received_byte_in,
    output logic                         received_byte_ready_out,
    // Monitor side, outgoing bytes
    output logic                         outgoing_byte_valid_out,
    output monitor_port_pkg::byte_t      outgoing_byte_out,
    input  wire logic                    outgoing_byte_ready_in,
    // Interrupt
    output logic                         interrupt_out
);
    import monitor_port_pkg::*;

    // Interface-select; the register set only exists for value 0.
    localparam int INTERFACE_SEL = 0;

    logic       rst_meta_r;
    logic       rst_sync_r;
    bus_state_t bus_state_r;
    logic       irq_en_r;
    logic       rx_clr;
    logic       tx_clr;
    logic       rx_push;
    logic       rx_pop;
    logic       tx_push;
    logic       tx_pop;
    byte_t      rx_data;
    byte_t      tx_data;
    logic       rx_empty;
    logic       rx_full;
    logic       tx_empty;
    logic       tx_full;
    logic       tx_fifo_empty;
    logic       tx_sent;
    logic [5:0] rx_level_r;
    logic [5:0] rx_level_nxt;
    logic [5:0] tx_level_r;
    logic [5:0] tx_level_nxt;
    logic       wr_take;
    logic       rd_take;
    logic       cmd_wr;
    logic       rx_empty_d_r;
    logic       tx_empty_d_r;
    logic [7:0] status;
    logic       out_valid_r;
    byte_t      out_byte_r;

    // Reset is released synchronously so all state leaves reset together.
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // One access at a time; a write needs address and data together.
    assign wr_take = (bus_state_r == BUS_IDLE) && s_axi_awvalid_in && s_axi_wvalid_in
                     && (INTERFACE_SEL == 0);
    assign rd_take = (bus_state_r == BUS_IDLE) && s_axi_arvalid_in && !wr_take
                     && (INTERFACE_SEL == 0);

    assign cmd_wr  = wr_take && (s_axi_awaddr_in == `MON_OFS_CMD) && s_axi_wstrb_in[0];
    assign rx_clr  = cmd_wr && s_axi_wdata_in[`MON_CMD_RX_CLR];
    assign tx_clr  = cmd_wr && s_axi_wdata_in[`MON_CMD_TX_CLR];
    assign tx_push = wr_take && (s_axi_awaddr_in == `MON_OFS_TX) && s_axi_wstrb_in[0]
                     && !tx_full;
    assign rx_pop  = rd_take && (s_axi_araddr_in == `MON_OFS_RX);
    assign rx_push = received_byte_valid_in && received_byte_ready_out;
    assign tx_pop  = !out_valid_r || outgoing_byte_ready_in;
    assign tx_sent = out_valid_r && outgoing_byte_ready_in;

    // The byte parked in the output register still counts as a transmit entry,
    // so full, empty and clear cover every byte that software queued.
    assign tx_level_nxt = tx_clr ? 6'h00 : tx_level_r + 6'(tx_push) - 6'(tx_sent);
    assign rx_level_nxt = rx_clr ? 6'h00 : rx_level_r + 6'(rx_push) - 6'(rx_pop && !rx_empty);
    assign tx_empty = (tx_level_r == 6'h00);
    assign tx_full  = (tx_level_r == 6'(`MON_FIFO_DEPTH));

    assign status = {3'b000,
                     irq_en_r,
                     tx_full,
                     tx_empty,
                     rx_full,
                     !rx_empty};

    monitor_byte_fifo rx_fifo (
        .clock_in     (clock_in),
        .rst_b_in     (rst_sync_r),
        .clear_in     (rx_clr),
        .push_in      (rx_push),
        .push_data_in (received_byte_in),
        .pop_in       (rx_pop),
        .pop_data_out (rx_data),
        .empty_out    (rx_empty),
        .full_out     (rx_full)
    );

    monitor_byte_fifo tx_fifo (
        .clock_in     (clock_in),
        .rst_b_in     (rst_sync_r),
        .clear_in     (tx_clr),
        .push_in      (tx_push),
        .push_data_in (s_axi_wdata_in[7:0]),
        .pop_in       (tx_pop),
        .pop_data_out (tx_data),
        .empty_out    (tx_fifo_empty),
        .full_out     ()
    );

    always_ff @(posedge clock_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            bus_state_r       <= BUS_IDLE;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
            s_axi_arready_out <= 1'b0;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= `AXI_RESP_OKAY;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rresp_out   <= `AXI_RESP_OKAY;
            s_axi_rdata_out   <= 32'h0000_0000;
        end else begin
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
            s_axi_arready_out <= 1'b0;
            case (bus_state_r)
                BUS_IDLE: begin
                    if (wr_take) begin
                        s_axi_awready_out <= 1'b1;
                        s_axi_wready_out  <= 1'b1;
                        s_axi_bvalid_out  <= 1'b1;
                        bus_state_r       <= BUS_WRESP;
                        // Receive, status and control writes all answer OKAY.
                        if (s_axi_awaddr_in == `MON_OFS_TX && tx_full) begin
                            s_axi_bresp_out <= `AXI_RESP_SLVERR;
                        end else begin
                            s_axi_bresp_out <= `AXI_RESP_OKAY;
                        end
                    end else if (rd_take) begin
                        s_axi_arready_out <= 1'b1;
                        s_axi_rvalid_out  <= 1'b1;
                        bus_state_r       <= BUS_RDATA;
                        s_axi_rresp_out   <= `AXI_RESP_OKAY;
                        s_axi_rdata_out   <= 32'h0000_0000;
                        if (s_axi_araddr_in == `MON_OFS_RX) begin
                            s_axi_rdata_out <= {24'h000000, rx_data};
                            if (rx_empty) begin
                                s_axi_rresp_out <= `AXI_RESP_SLVERR;
                            end
                        end else if (s_axi_araddr_in == `MON_OFS_STATE) begin
                            s_axi_rdata_out <= {24'h000000, status};
                        end
                    end
                end
                BUS_WRESP: begin
                    if (s_axi_bready_in) begin
                        s_axi_bvalid_out <= 1'b0;
                        bus_state_r      <= BUS_IDLE;
                    end
                end
                BUS_RDATA: begin
                    if (s_axi_rready_in) begin
                        s_axi_rvalid_out <= 1'b0;
                        bus_state_r      <= BUS_IDLE;
                    end
                end
                default: begin
                    bus_state_r <= BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            irq_en_r <= 1'b0;
        end else if (cmd_wr) begin
            irq_en_r <= s_axi_wdata_in[`MON_CMD_IRQ_EN];
        end
    end

    // Output stage keeps the outgoing stream registered.
    always_ff @(posedge clock_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            out_valid_r <= 1'b0;
            out_byte_r  <= 8'h00;
        end else if (tx_clr) begin
            out_valid_r <= 1'b0;
        end else if (tx_pop) begin
            out_valid_r <= !tx_fifo_empty;
            out_byte_r  <= tx_data;
        end
    end

    assign outgoing_byte_valid_out = out_valid_r;
    assign outgoing_byte_out       = out_byte_r;

    always_ff @(posedge clock_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            rx_level_r              <= 6'h00;
            tx_level_r              <= 6'h00;
            received_byte_ready_out <= 1'b0;
        end else begin
            rx_level_r              <= rx_level_nxt;
            tx_level_r              <= tx_level_nxt;
            // Ready is registered, so it follows the next level and falls at the
            // very edge that fills the last free entry; no byte is lost to overflow, but a byte taken in the cycle of a receive clear is dropped.
            received_byte_ready_out <= (rx_level_nxt != 6'(`MON_FIFO_DEPTH));
        end
    end

    always_ff @(posedge clock_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            rx_empty_d_r  <= 1'b1;
            tx_empty_d_r  <= 1'b1;
            interrupt_out <= 1'b0;
        end else begin
            rx_empty_d_r  <= rx_empty;
            tx_empty_d_r  <= tx_empty;
            interrupt_out <= irq_en_r && ((rx_empty_d_r && !rx_empty)
                             || (!tx_empty_d_r && tx_empty));
        end
    end

    AST_STATUS_RESET_EMPTY: assert property (@(posedge clock_in) disable iff (!rst_sync_r)
        $rose(rst_sync_r) |-> status == 8'h04)
        else $error("Status not 0x04 after reset.");

    AST_RX_EMPTY_SLVERR: assert property (@(posedge clock_in) disable iff (!rst_sync_r)
        rd_take && s_axi_araddr_in == `MON_OFS_RX && rx_empty
        |=> s_axi_rvalid_out && s_axi_rresp_out == `AXI_RESP_SLVERR)
        else $error("Empty receive read did not give SLVERR.");

    AST_TX_FULL_SLVERR: assert property (@(posedge clock_in) disable iff (!rst_sync_r)
        wr_take && s_axi_awaddr_in == `MON_OFS_TX && tx_full
        |=> s_axi_bresp_out == `AXI_RESP_SLVERR && tx_full)
        else $error("Full transmit write not refused.");

    AST_TX_READ_ZERO: assert property (@(posedge clock_in) disable iff (!rst_sync_r)
        rd_take && s_axi_araddr_in == `MON_OFS_TX
        |=> s_axi_rdata_out == 32'h0000_0000 && s_axi_rresp_out == `AXI_RESP_OKAY)
        else $error("Transmit read not zero OKAY.");

    AST_CMD_READ_ZERO: assert property (@(posedge clock_in) disable iff (!rst_sync_r)
        rd_take && s_axi_araddr_in == `MON_OFS_CMD |=> s_axi_rdata_out == 32'h0000_0000)
        else $error("Control read not zero.");

    AST_IRQ_EN_WRITE: assert property (@(posedge clock_in) disable iff (!rst_sync_r)
        cmd_wr |=> irq_en_r == $past(s_axi_wdata_in[`MON_CMD_IRQ_EN]))
        else $error("Interrupt enable not taken from write.");

    AST_RX_CLEAR: assert property (@(posedge clock_in) disable iff (!rst_sync_r)
        rx_clr |=> rx_empty)
        else $error("Receive FIFO not emptied.");

    AST_TX_CLEAR: assert property (@(posedge clock_in) disable iff (!rst_sync_r)
        tx_clr |=> tx_empty ##1 tx_empty || tx_push)
        else $error("Transmit FIFO not emptied.");

    AST_STATUS_READ: assert property (@(posedge clock_in) disable iff (!rst_sync_r)
        rd_take && s_axi_araddr_in == `MON_OFS_STATE
        |=> s_axi_rdata_out[7:5] == 3'b000
            && s_axi_rdata_out[4] == $past(irq_en_r))
        else $error("Status read wrong.");

    AST_IRQ_GATED: assert property (@(posedge clock_in) disable iff (!rst_sync_r)
        interrupt_out |-> $past(irq_en_r))
        else $error("Interrupt pulsed while disabled.");

    AST_STATUS_WRITE_OKAY: assert property (@(posedge clock_in) disable iff (!rst_sync_r)
        wr_take && s_axi_awaddr_in == `MON_OFS_STATE
        |=> s_axi_bvalid_out && s_axi_bresp_out == `AXI_RESP_OKAY)
        else $error("Status write not acknowledged OKAY.");
endmodule
`default_nettype wire

// ===== verilog/monitor_port_map.svh
`ifndef MONITOR_PORT_MAP_SVH
`define MONITOR_PORT_MAP_SVH

`define MON_OFS_RX          4'h0
`define MON_OFS_TX          4'h4
`define MON_OFS_STATE       4'h8
`define MON_OFS_CMD         4'hC
`define MON_FIFO_DEPTH      32
`define MON_FIFO_AW         5
`define MON_ST_RX_VALID     0
`define MON_ST_RX_FULL      1
`define MON_ST_TX_EMPTY     2
`define MON_ST_TX_FULL      3
`define MON_ST_IRQ_EN       4
`define MON_CMD_TX_CLR      0
`define MON_CMD_RX_CLR      1
`define MON_CMD_IRQ_EN      4
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2

`endif

// ===== verilog/monitor_port_pkg.sv
package monitor_port_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [1:0] resp_t;
    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,
        BUS_WRESP = 3'b010,
        BUS_RDATA = 3'b100
    } bus_state_t;
endpackage

// ===== verilog/monitor_byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "monitor_port_map.svh"

// Byte FIFO with synchronous clear; clear wins over a same-cycle push or pop.
module monitor_byte_fifo
    import monitor_port_pkg::*;
(
    // Clock and reset
    input  wire logic                   clock_in,
    input  wire logic                   rst_b_in,
    // Control
    input  wire logic                   clear_in,
    // Write side
    input  wire logic                   push_in,
    input  wire monitor_port_pkg::byte_t push_data_in,
    // Read side
    input  wire logic                   pop_in,
    output monitor_port_pkg::byte_t     pop_data_out,
    // Levels
    output logic                        empty_out,
    output logic                        full_out
);
    import monitor_port_pkg::*;

    byte_t                    mem [`MON_FIFO_DEPTH];
    logic [`MON_FIFO_AW-1:0]  wr_ptr_r;
    logic [`MON_FIFO_AW-1:0]  rd_ptr_r;
    logic [`MON_FIFO_AW:0]    count_r;
    logic                     do_push;
    logic                     do_pop;

    assign do_push = push_in && !full_out;
    assign do_pop  = pop_in && !empty_out;
    assign empty_out = (count_r == '0);
    assign full_out  = (count_r == (`MON_FIFO_AW+1)'(`MON_FIFO_DEPTH));
    assign pop_data_out = mem[rd_ptr_r];

    always_ff @(posedge clock_in) begin
        if (do_push) begin
            mem[wr_ptr_r] <= push_data_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else if (clear_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_r <= count_r + 1'b1;
            end else if (do_pop && !do_push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/monitor_peer_model.sv
`timescale 1ns/1ps
`default_nettype none

// Behavioural stand-in for the error-mitigation controller's monitor link.
module monitor_peer_model
    import monitor_port_pkg::*;
(
    // Clock
    input  wire logic                    clock_in,
    // Flow control from the bench
    input  wire logic                    stall_in,
    // Bytes sent toward the block
    output logic                         byte_valid_out,
    output monitor_port_pkg::byte_t      byte_out,
    input  wire logic                    byte_ready_in,
    // Bytes taken from the block
    input  wire logic                    take_valid_in,
    input  wire monitor_port_pkg::byte_t take_byte_in,
    output logic                         take_ready_out
);
    byte_t got_q[$];

    initial begin
        byte_valid_out = 1'b0;
        byte_out = 8'hA5;
        take_ready_out = 1'b0;
    end

    always @(posedge clock_in) begin
        take_ready_out <= !stall_in;
    end

    always @(posedge clock_in) begin
        if (take_valid_in === 1'b1 && take_ready_out === 1'b1) begin
            got_q.push_back(take_byte_in);
        end
    end

    // The byte is held until ready is seen at an edge; afterwards the line shows
    // the inverse so that a stale value can never be mistaken for fresh data.
    task automatic send_byte(input byte_t b);
        int n;
        n = 0;
        @(posedge clock_in);
        byte_valid_out <= 1'b1;
        byte_out <= b;
        do begin
            @(posedge clock_in);
            n++;
        end while (byte_ready_in !== 1'b1 && n < 64);
        byte_valid_out <= 1'b0;
        byte_out <= ~b;
    endtask
endmodule

`default_nettype wire

// ===== dv/sem_monitor_fifo_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "monitor_port_map.svh"

module sem_monitor_fifo_port_tb;
    import monitor_port_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  aw_addr = 4'h0;
    logic [3:0]  ar_addr = 4'h0;
    logic [31:0] w_data = 32'h0;
    logic        aw_vld = 1'b0;
    logic        w_vld = 1'b0;
    logic        b_rdy = 1'b0;
    logic        ar_vld = 1'b0;
    logic        r_rdy = 1'b0;
    logic        stall = 1'b1;
    wire logic   aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, irq, rx_vld, rx_rdy, tx_vld, tx_rdy;
    wire resp_t  b_resp, r_resp;
    wire byte_t  rx_byte, tx_byte;
    wire logic [31:0] r_data;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          irq_cnt = 0;

    sem_monitor_fifo_port uut (
        .clock_in(clk), .rst_b_in(rst_b),
        .s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_vld), .s_axi_awready_out(aw_rdy),
        .s_axi_wdata_in(w_data), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(w_vld),
        .s_axi_wready_out(w_rdy), .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_vld),
        .s_axi_bready_in(b_rdy), .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_vld),
        .s_axi_arready_out(ar_rdy), .s_axi_rdata_out(r_data), .s_axi_rresp_out(r_resp),
        .s_axi_rvalid_out(r_vld), .s_axi_rready_in(r_rdy),
        .received_byte_valid_in(rx_vld), .received_byte_in(rx_byte),
        .received_byte_ready_out(rx_rdy), .outgoing_byte_valid_out(tx_vld),
        .outgoing_byte_out(tx_byte), .outgoing_byte_ready_in(tx_rdy), .interrupt_out(irq));

    monitor_peer_model peer (
        .clock_in(clk), .stall_in(stall), .byte_valid_out(rx_vld), .byte_out(rx_byte),
        .byte_ready_in(rx_rdy), .take_valid_in(tx_vld), .take_byte_in(tx_byte),
        .take_ready_out(tx_rdy));

    initial begin
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (irq === 1'b1) irq_cnt++;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Valids and readies drop only after the edge that sampled the answer.
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d, input resp_t exp);
        int n;
        n = 0;
        @(posedge clk);
        aw_addr <= a;
        w_data <= d;
        aw_vld <= 1'b1;
        w_vld <= 1'b1;
        b_rdy <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (aw_rdy !== 1'b1 && n < 64);
        check("bvalid", 32'h1, {31'h0, b_vld});
        check("wready", 32'h1, {31'h0, w_rdy});
        check("bresp", {30'h0, exp}, {30'h0, b_resp});
        aw_vld <= 1'b0;
        w_vld <= 1'b0;
        b_rdy <= 1'b0;
    endtask

    task automatic bus_rd(input logic [3:0] a, input logic [31:0] exp, input resp_t exp_r);
        int n;
        n = 0;
        @(posedge clk);
        ar_addr <= a;
        ar_vld <= 1'b1;
        r_rdy <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (ar_rdy !== 1'b1 && n < 64);
        check("rvalid", 32'h1, {31'h0, r_vld});
        check("rresp", {30'h0, exp_r}, {30'h0, r_resp});
        if (exp_r === `AXI_RESP_OKAY) check("rdata", exp, r_data);
        ar_vld <= 1'b0;
        r_rdy <= 1'b0;
    endtask

    task automatic st(input logic [7:0] e);
        bus_rd(`MON_OFS_STATE, {24'h0, e}, `AXI_RESP_OKAY);
    endtask

    task automatic summarize();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Whole sequence needs well under two thousand cycles.
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        summarize();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        st(8'h04);
        bus_rd(`MON_OFS_RX, 32'h0, `AXI_RESP_SLVERR);
        bus_rd(`MON_OFS_TX, 32'h0, `AXI_RESP_OKAY);
        bus_rd(`MON_OFS_CMD, 32'h0, `AXI_RESP_OKAY);
        bus_rd(4'h2, 32'h0, `AXI_RESP_OKAY);
        bus_wr(`MON_OFS_STATE, 32'h0000_00FF, `AXI_RESP_OKAY);
        bus_wr(`MON_OFS_RX, 32'h0000_00A5, `AXI_RESP_OKAY);
        st(8'h04);
        for (int i = 0; i < `MON_FIFO_DEPTH; i++) begin
            peer.send_byte(8'(i) ^ 8'h3C);
        end
        repeat (2) @(posedge clk);
        st(8'h07);
        bus_wr(`MON_OFS_CMD, 32'h0, `AXI_RESP_OKAY);
        st(8'h07);
        for (int i = 0; i < 3; i++) begin
            bus_rd(`MON_OFS_RX, {24'h0, 8'(i) ^ 8'h3C}, `AXI_RESP_OKAY);
        end
        st(8'h05);
        bus_wr(`MON_OFS_CMD, 32'h0000_0002, `AXI_RESP_OKAY);
        st(8'h04);
        bus_rd(`MON_OFS_RX, 32'h0, `AXI_RESP_SLVERR);
        for (int i = 0; i < `MON_FIFO_DEPTH; i++) begin
            bus_wr(`MON_OFS_TX, {24'h0, 8'(i)}, `AXI_RESP_OKAY);
        end
        st(8'h08);
        bus_wr(`MON_OFS_TX, 32'h0000_00EE, `AXI_RESP_SLVERR);
        bus_wr(`MON_OFS_CMD, 32'h0000_0001, `AXI_RESP_OKAY);
        st(8'h04);
        for (int i = 0; i < 3; i++) begin
            bus_wr(`MON_OFS_TX, {24'h0, 8'h50 + 8'(i)}, `AXI_RESP_OKAY);
        end
        stall <= 1'b0;
        repeat (20) @(posedge clk);
        check("tx count", 32'd3, 32'(peer.got_q.size()));
        for (int i = 0; i < peer.got_q.size(); i++) begin
            check("tx byte", {24'h0, 8'h50 + 8'(i)}, {24'h0, peer.got_q[i]});
        end
        st(8'h04);
        check("irq off", 32'h0, 32'(irq_cnt));
        bus_wr(`MON_OFS_CMD, 32'h0000_0010, `AXI_RESP_OKAY);
        st(8'h14);
        peer.send_byte(8'h77);
        repeat (8) @(posedge clk);
        check("irq rx", 32'h1, 32'(irq_cnt));
        bus_rd(`MON_OFS_RX, 32'h0000_0077, `AXI_RESP_OKAY);
        bus_wr(`MON_OFS_TX, 32'h0000_0061, `AXI_RESP_OKAY);
        repeat (20) @(posedge clk);
        check("irq tx", 32'h2, 32'(irq_cnt));
        bus_wr(`MON_OFS_CMD, 32'h0, `AXI_RESP_OKAY);
        peer.send_byte(8'h78);
        repeat (8) @(posedge clk);
        st(8'h05);
        check("irq masked", 32'h2, 32'(irq_cnt));
        bus_rd(`MON_OFS_RX, 32'h0000_0078, `AXI_RESP_OKAY);
        summarize();
    end
endmodule

`default_nettype wire
